// ==== ssp_top.sv ====
// Purpose: Scan sequencer with arm, scan and channel layers and pattern store
// Assumes: AHB-Lite slave, zero wait states, one clock sys_clk
// Notes:   Pattern storage has no reset so contents persist
// Behaviour
// - Event arm spacing waits before scan layer
// - Scan layer holds until scan spacing event
// - Channel events select next list entry
// - Immediate scan spacing loops straight to channels
// - Final channel of final scan of final arm disarms
// - Step always counts as spacing event
// - Forbidden channels refused from scan list
// - Single closure keeps lowest pattern channel
// - Pairing drives matching channel in paired slot
// - Open-all aborts, opens, idles; step leaves idle
// - Five hundred full pattern locations
// - Patterns kept in non-volatile storage; here flops with no reset
// - Missing closed channel clears pattern
// - Restricted closed channel clears pattern
// - Two interlocked closed channels clear pattern
// - Paired counterparts join restriction, interlock checks
// - Clearing a listed pattern clears scan list
// - Store live relays or defined list
// - Location defaults 001, accepts 001 to 500
// - Recall updates relays with status together
// - Listed location reinstates its pattern
// - Pattern channels stay closed later in scan
// - Counts 1 to 9999 or infinite
//
// The AHB-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ssp_top
  import ssp_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        ext_trig,
  input  wire logic        chained_trigger_line,
  input  wire logic        step_key,
  output logic      [31:0] relay_drive,
  output logic             armed
);
  ////////////////////////////////////////////////////////////////////////
  // Helper functions
  // Mirror closed channels into the paired slot
  function automatic logic [31:0] pair_exp(input logic [31:0] p, input logic en);
    pair_exp = en ? (p | {p[HALF-1:0], p[NCH-1:HALF]}) : p;
  endfunction : pair_exp
  // Keep only the lowest closed channel
  function automatic logic [31:0] lowest(input logic [31:0] p);
    lowest = p & (~p + 32'h0000_0001);
  endfunction : lowest
  // Event of the chosen spacing source
  function automatic logic src_evt(input logic [2:0] s, input logic [4:0] e);
    case (s)
      SP_IMM:   src_evt = 1'b1;
      SP_TIMER: src_evt = e[0];
      SP_EXT:   src_evt = e[1];
      SP_BUS:   src_evt = e[2];
      SP_CHAIN: src_evt = e[3];
      default:  src_evt = 1'b0;
    endcase
  endfunction : src_evt
  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [31:0]      cfg_reg;                 // Spacing, modes
  logic [31:0]      cnt_reg;                 // Arm and scan counts
  logic [31:0]      tmr_reg;                 // Timer period
  logic [8:0]       loc_reg;                 // Store and recall location
  logic [31:0]      clist_reg;               // Defined channel list
  logic [31:0]      forb_reg;                // Forbidden channels
  logic [31:0]      restr_reg;               // Restricted channels
  logic [31:0]      ilock_reg;               // Interlocked channels
  logic [31:0]      avail_reg;               // Present channels
  logic             refused_reg;             // Sticky refusal flag
  ssp_entry_s       list_reg [LIST_D];       // Scan list
  logic [4:0]       llen_reg;                // Scan list length
  logic [31:0]      pat_mem [NLOC];          // Pattern storage
  logic [NLOC-1:0]  pat_ok;                  // Location holds a pattern
  ssp_state_e       state_reg;               // Sequencer layer
  logic [3:0]       lptr_reg;                // Next list entry
  logic [13:0]      arm_n_reg;               // Arms done
  logic [13:0]      scan_n_reg;              // Scans done in this arm
  logic [31:0]      hold_reg;                // Channels held by patterns
  logic [31:0]      tcnt_reg;                // Timer count
  logic             sweep_reg;               // Validity sweep running
  logic [8:0]       sidx_reg;                // Sweep index
  // Bus phase capture
  logic             wr_ph;
  logic [7:0]       wr_adr;
  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, change taken when stages two and three agree
  logic [2:0]       pin_in;
  logic [2:0]       pin_evt;                 // One pulse per rising change
  assign pin_in = {step_key, chained_trigger_line, ext_trig};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      logic s1, s2, s3, lvl;
      // Shift the pin through three flops
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          s1  <= 1'b0;
          s2  <= 1'b0;
          s3  <= 1'b0;
          lvl <= 1'b0;
        end else begin
          s1  <= pin_in[gi];
          s2  <= s1;
          s3  <= s2;
          if (s2 == s3) begin
            lvl <= s3;
          end
        end
      end
      assign pin_evt[gi] = (s2 == s3) && s3 && !lvl;
    end
  endgenerate
  ////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: always ready, always OKAY
  logic wr_go, rd_go;
  assign wr_go     = hsel && hready && htrans[1] && hwrite;
  assign rd_go     = hsel && hready && htrans[1] && !hwrite;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  // Hold address of a write into its data phase
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ph  <= 1'b0;
      wr_adr <= 8'h00;
    end else if (hready) begin
      wr_ph  <= wr_go;
      wr_adr <= haddr[7:0];
    end
  end
  // Write strobes in the data phase
  logic        we_cmd, we_ladd;
  logic [31:0] cmd;
  assign we_cmd  = wr_ph && (wr_adr == A_CMD);
  assign we_ladd = wr_ph && (wr_adr == A_LADD);
  assign cmd     = we_cmd ? hwdata : 32'h0000_0000;
  logic        step_ev, open_cmd, bus_trg, loc_ok;
  assign step_ev  = cmd[C_STEP] || pin_evt[2];
  assign open_cmd = cmd[C_OPEN];
  assign bus_trg  = cmd[C_BUSTRG];
  assign loc_ok   = (loc_reg >= LOC_MIN) && (loc_reg <= LOC_MAX);
  // Read data, registered in the address phase
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_go) begin
      case (haddr[7:0])
        A_CFG:   hrdata <= cfg_reg;
        A_CNT:   hrdata <= cnt_reg;
        A_TMR:   hrdata <= tmr_reg;
        A_LOC:   hrdata <= {23'h000000, loc_reg};
        A_CLIST: hrdata <= clist_reg;
        A_FORB:  hrdata <= forb_reg;
        A_RESTR: hrdata <= restr_reg;
        A_ILOCK: hrdata <= ilock_reg;
        A_AVAIL: hrdata <= avail_reg;
        A_STAT:  hrdata <= {23'h000000, refused_reg, sweep_reg, llen_reg, state_reg};
        A_RELAY: hrdata <= relay_drive;
        default: hrdata <= 32'h0000_0000;   // Unmapped reads zero
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg   <= 32'h0000_0000;
      cnt_reg   <= 32'h0001_0001;
      tmr_reg   <= RST_TMR;
      loc_reg   <= RST_LOC;
      clist_reg <= 32'h0000_0000;
      forb_reg  <= 32'h0000_0000;
      restr_reg <= 32'h0000_0000;
      ilock_reg <= 32'h0000_0000;
      avail_reg <= RST_AVL;
    end else if (wr_ph) begin
      case (wr_adr)
        A_CFG:   cfg_reg   <= hwdata;
        // Clamp finite counts to the largest allowed; zero means infinite
        A_CNT:   cnt_reg   <= {2'b00, (hwdata[29:16] > CNT_MAX) ? CNT_MAX : hwdata[29:16],
                               2'b00, (hwdata[13:0] > CNT_MAX) ? CNT_MAX : hwdata[13:0]};
        A_TMR:   tmr_reg   <= hwdata;
        A_LOC:   loc_reg   <= hwdata[8:0];
        A_CLIST: clist_reg <= hwdata;
        A_FORB:  forb_reg  <= hwdata;
        A_RESTR: restr_reg <= hwdata;
        A_ILOCK: ilock_reg <= hwdata;
        A_AVAIL: avail_reg <= hwdata;
        default: ;
      endcase
    end
  end
  logic pair_en, single_en;
  assign pair_en   = cfg_reg[F_PAIR];
  assign single_en = cfg_reg[F_SINGLE];
  ////////////////////////////////////////////////////////////////////////
  // Validity sweep: started by any change to channel availability
  logic        cfg_chg, sw_bad, sw_hit;
  logic [31:0] sw_pat, sw_exp, sw_il;
  assign cfg_chg = wr_ph && (wr_adr == A_AVAIL || wr_adr == A_RESTR ||
                             wr_adr == A_ILOCK || wr_adr == A_CFG);
  assign sw_pat  = pat_mem[sidx_reg];
  assign sw_exp  = pair_exp(sw_pat, pair_en);
  assign sw_il   = sw_exp & ilock_reg;
  assign sw_bad  = sweep_reg && pat_ok[sidx_reg] &&
                   (((sw_pat & ~avail_reg) != 32'h0000_0000) ||
                    ((sw_exp & restr_reg) != 32'h0000_0000) ||
                    ((sw_il & (sw_il - 32'h0000_0001)) != 32'h0000_0000));
  // Swept location referenced by the scan list
  always_comb begin
    sw_hit = 1'b0;
    for (int i = 0; i < LIST_D; i++) begin
      if (5'(i) < llen_reg && list_reg[i].is_pat &&
          list_reg[i].idx == sidx_reg + 9'h001) begin
        sw_hit = 1'b1;
      end
    end
  end
  // Walk all locations once per change, restarting on a new change
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sweep_reg <= 1'b0;
      sidx_reg  <= 9'h000;
    end else if (cfg_chg) begin
      sweep_reg <= 1'b1;
      sidx_reg  <= 9'h000;
    end else if (sweep_reg) begin
      sweep_reg <= (sidx_reg != LOC_MAX - 9'h001);
      sidx_reg  <= sidx_reg + 9'h001;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Pattern storage: no reset, contents persist
  logic [8:0]  st_idx;
  logic        do_store;
  assign st_idx   = loc_reg - 9'h001;
  assign do_store = cmd[C_STORE] && loc_ok;
  always_ff @(posedge sys_clk) begin
    if (do_store) begin
      pat_mem[st_idx] <= cfg_reg[F_SRCLST] ? clist_reg : relay_drive;
      pat_ok[st_idx]  <= 1'b1;
    end else if (sw_bad) begin
      pat_mem[sidx_reg] <= 32'h0000_0000;
      pat_ok[sidx_reg]  <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Scan list: append, refuse, clear
  ssp_entry_s  new_ent;
  logic        ent_bad;
  assign new_ent = ssp_entry_s'(hwdata[9:0]);
  assign ent_bad = new_ent.is_pat ?
                   (new_ent.idx < LOC_MIN || new_ent.idx > LOC_MAX) :
                   (new_ent.idx > 9'(NCH - 1) || forb_reg[new_ent.idx[4:0]]);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      llen_reg <= 5'h00;
      for (int i = 0; i < LIST_D; i++) begin
        list_reg[i] <= '0;
      end
    end else if (cmd[C_LCLR] || (sw_bad && sw_hit)) begin
      llen_reg <= 5'h00;
    end else if (we_ladd && !ent_bad && llen_reg != 5'(LIST_D)) begin
      list_reg[llen_reg[3:0]] <= new_ent;
      llen_reg                <= llen_reg + 5'h01;
    end
  end
  // Sticky refusal: set wins over acknowledge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      refused_reg <= 1'b0;
    end else if ((we_ladd && (ent_bad || llen_reg == 5'(LIST_D))) ||
                 ((cmd[C_STORE] || cmd[C_RECALL]) && !loc_ok) ||
                 (cmd[C_RECALL] && loc_ok && !pat_ok[st_idx])) begin
      refused_reg <= 1'b1;
    end else if (cmd[C_ACK]) begin
      refused_reg <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Spacing timer, runs while armed
  logic tmr_tick;
  assign tmr_tick = (state_reg != ST_IDLE) && (tcnt_reg + 32'h0000_0001 >= tmr_reg);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tcnt_reg <= 32'h0000_0000;
    end else if (state_reg == ST_IDLE || tmr_tick) begin
      tcnt_reg <= 32'h0000_0000;
    end else begin
      tcnt_reg <= tcnt_reg + 32'h0000_0001;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Layer events; step counts in every layer
  logic [4:0] evs;
  logic       arm_ev, scan_ev, chan_ev, scan_imm;
  logic       last_ent, last_scan, last_arm;
  assign evs       = {1'b0, pin_evt[1], bus_trg, pin_evt[0], tmr_tick};
  assign arm_ev    = src_evt(cfg_reg[F_ARM +: 3], evs) || step_ev;
  assign scan_ev   = src_evt(cfg_reg[F_SCAN +: 3], evs) || step_ev;
  assign chan_ev   = src_evt(cfg_reg[F_CHAN +: 3], evs) || step_ev;
  assign scan_imm  = cfg_reg[F_SCAN +: 3] == SP_IMM;
  assign last_ent  = {1'b0, lptr_reg} + 5'h01 >= llen_reg;
  assign last_scan = (cnt_reg[F_SCNT +: CNT_W] != 14'h0000) &&
                     (scan_n_reg + 14'h0001 >= cnt_reg[F_SCNT +: CNT_W]);
  assign last_arm  = (cnt_reg[CNT_W-1:0] != 14'h0000) &&
                     (arm_n_reg + 14'h0001 >= cnt_reg[CNT_W-1:0]);
  logic sel_now;                              // An entry is selected now
  assign sel_now = (state_reg == ST_CHAN) && chan_ev && !open_cmd;
  ////////////////////////////////////////////////////////////////////////
  // Sequencer layers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg  <= ST_IDLE;
      lptr_reg   <= 4'h0;
      arm_n_reg  <= 14'h0000;
      scan_n_reg <= 14'h0000;
    end else if (open_cmd || (sw_bad && sw_hit)) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (step_ev && llen_reg != 5'h00) begin
            state_reg  <= ST_ARM;
            lptr_reg   <= 4'h0;
            arm_n_reg  <= 14'h0000;
            scan_n_reg <= 14'h0000;
          end
        end
        ST_ARM: begin
          if (cfg_reg[F_ARM +: 3] == SP_IMM || arm_ev) begin
            state_reg <= ST_SCAN;
          end
        end
        ST_SCAN: begin
          if (scan_ev) begin
            state_reg <= ST_CHAN;
          end
        end
        ST_CHAN: begin
          if (chan_ev) begin
            lptr_reg <= lptr_reg + 4'h1;
            if (last_ent) begin
              lptr_reg <= 4'h0;
              if (!last_scan) begin
                scan_n_reg <= scan_n_reg + 14'h0001;
                state_reg  <= scan_imm ? ST_CHAN : ST_SCAN;
              end else if (!last_arm) begin
                scan_n_reg <= 14'h0000;
                arm_n_reg  <= arm_n_reg + 14'h0001;
                state_reg  <= ST_ARM;
              end else begin
                state_reg <= ST_IDLE;
              end
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
  assign armed = (state_reg != ST_IDLE);
  ////////////////////////////////////////////////////////////////////////
  // Relay drive: selection, recall, open-all
  ssp_entry_s  cur;
  logic [31:0] cur_pat, rc_pat;
  assign cur     = list_reg[lptr_reg];
  assign cur_pat = single_en ? lowest(pat_mem[cur.idx - 9'h001])
                             : pat_mem[cur.idx - 9'h001];
  assign rc_pat  = single_en ? lowest(pat_mem[st_idx]) : pat_mem[st_idx];
  // Channels held closed by scanned patterns
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_reg <= 32'h0000_0000;
    end else if (open_cmd || (state_reg == ST_IDLE && step_ev)) begin
      hold_reg <= 32'h0000_0000;
    end else if (sel_now && cur.is_pat) begin
      hold_reg <= hold_reg | cur_pat;
    end
  end
  // Relay outputs, status readback is this same register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      relay_drive <= 32'h0000_0000;
    end else if (open_cmd) begin
      relay_drive <= 32'h0000_0000;
    end else if (sel_now) begin
      relay_drive <= pair_exp(hold_reg | (cur.is_pat ? cur_pat :
                     (32'h0000_0001 << cur.idx[4:0])), pair_en);
    end else if (cmd[C_RECALL] && loc_ok && pat_ok[st_idx]) begin
      relay_drive <= pair_exp(rc_pat, pair_en);
    end
  end
endmodule : ssp_top
`default_nettype wire

// ==== ssp_pkg.sv ====
// Purpose: Shared constants and types for the scan sequencer and pattern store
// Assumes: 32 relay channels in two slots of 16; slot 0 pairs with slot 1
// Notes:   Bus register offsets are byte addresses on AHB-Lite
package ssp_pkg;
  localparam int          NCH      = 32;            // Relay channels
  localparam int          HALF     = 16;            // Channels per slot
  localparam int          NLOC     = 500;           // Pattern locations
  localparam int          LIST_D   = 16;            // Scan list depth
  localparam int          CNT_W    = 14;            // Count width
  localparam logic [13:0] CNT_MAX  = 14'h270f;      // Largest finite count
  localparam logic [8:0]  LOC_MIN  = 9'h001;        // First location
  localparam logic [8:0]  LOC_MAX  = 9'h1f4;        // Last location
  localparam logic [8:0]  RST_LOC  = 9'h001;        // Location after reset
  localparam logic [31:0] RST_TMR  = 32'h0000_03e8; // Timer period, cycles
  localparam logic [31:0] RST_AVL  = 32'hffff_ffff; // All channels present
  // Register byte offsets
  localparam logic [7:0]  A_CMD    = 8'h00;
  localparam logic [7:0]  A_CFG    = 8'h04;
  localparam logic [7:0]  A_CNT    = 8'h08;
  localparam logic [7:0]  A_TMR    = 8'h0c;
  localparam logic [7:0]  A_LOC    = 8'h10;
  localparam logic [7:0]  A_LADD   = 8'h14;
  localparam logic [7:0]  A_CLIST  = 8'h18;
  localparam logic [7:0]  A_FORB   = 8'h1c;
  localparam logic [7:0]  A_RESTR  = 8'h20;
  localparam logic [7:0]  A_ILOCK  = 8'h24;
  localparam logic [7:0]  A_AVAIL  = 8'h28;
  localparam logic [7:0]  A_STAT   = 8'h2c;
  localparam logic [7:0]  A_RELAY  = 8'h30;
  // Command bits (write one to act)
  localparam int          C_STEP   = 0;
  localparam int          C_OPEN   = 1;
  localparam int          C_STORE  = 2;
  localparam int          C_RECALL = 3;
  localparam int          C_BUSTRG = 4;
  localparam int          C_LCLR   = 5;
  localparam int          C_ACK    = 6;
  // Configuration fields
  localparam int          F_ARM    = 0;
  localparam int          F_SCAN   = 3;
  localparam int          F_CHAN   = 6;
  localparam int          F_SINGLE = 9;
  localparam int          F_PAIR   = 10;
  localparam int          F_SRCLST = 11;
  localparam int          F_SCNT   = 16;
  // Spacing sources
  typedef enum logic [2:0] {SP_IMM, SP_TIMER, SP_EXT, SP_BUS, SP_MAN, SP_CHAIN} ssp_src_e;
  // Sequencer layers
  typedef enum logic [1:0] {ST_IDLE, ST_ARM, ST_SCAN, ST_CHAN} ssp_state_e;
  // Scan list entry: channel number or pattern location
  typedef struct packed {
    logic       is_pat;
    logic [8:0] idx;
  } ssp_entry_s;
endpackage : ssp_pkg

// ==== ssp_checker.sv ====
// Purpose: Port checker for ssp_top
// Assumes: Zero-wait bus, one clock
// Notes:   Bound to every ssp_top
`timescale 1ns/1ps
`default_nettype none
module ssp_checker
  import ssp_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        step_key,
  input wire logic [31:0] relay_drive,
  input wire logic        armed
);
  logic       act_q, wr_q, key_q, pair_q; // Data phase, key and pairing trackers
  logic [7:0] a_q;                        // Address of the data phase
  logic [3:0] age_q;                      // Edges since the last step
  wire logic  rd_q   = act_q && !wr_q;
  wire logic  cmd_wr = act_q && wr_q && a_q == A_CMD;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  //////////////////////////////////////////////////////////////////////////////
  // Bus phase tracking
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      act_q <= 1'b0;
      wr_q  <= 1'b0;
      a_q   <= 8'h00;
    end else begin
      act_q <= hsel && hreadyout && htrans[1];
      wr_q  <= hwrite;
      a_q   <= haddr[7:0];
    end
  end
  // Step age and pairing mode
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      age_q  <= 4'hf;
      key_q  <= 1'b0;
      pair_q <= 1'b0;
    end else begin
      key_q <= step_key;
      if ((cmd_wr && hwdata[C_STEP]) || (step_key && !key_q)) age_q <= 4'h0;
      else if (age_q != 4'hf) age_q <= age_q + 4'h1;
      if (act_q && wr_q && a_q == A_CFG) pair_q <= hwdata[F_PAIR];
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  sequence open_cmd;
    cmd_wr && hwdata[C_OPEN];
  endsequence
  sequence all_open;
    (!armed && relay_drive == 32'h0) [*2];
  endsequence
  open_all_a: assert property (open_cmd |=> all_open)
    else $error("open-all left relays or sequencer active");
  arm_cause_a: assert property ($rose(armed) |-> age_q <= 4'h8)
    else $error("sequencer left idle without a step");
  stat_idle_a: assert property (rd_q && a_q == A_STAT |-> (hrdata[1:0] == 2'b00) == !$past(armed))
    else $error("status state disagrees with armed");
  relay_read_a: assert property (rd_q && a_q == A_RELAY |-> hrdata == $past(relay_drive))
    else $error("relay readback differs from drive");
  pair_halves_a: assert property (pair_q && armed && $changed(relay_drive)
    |-> relay_drive[15:0] == relay_drive[31:16])
    else $error("paired slot not driven alike");
  unmapped_a: assert property (rd_q && a_q > A_RELAY |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  reset_idle_a: assert property ($rose(rst_n) |-> !armed && relay_drive == 32'h0)
    else $error("not idle after reset");
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus wait or error response");
endmodule : ssp_checker
bind ssp_top ssp_checker u_chk (.sys_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hrdata, .hreadyout, .hresp, .step_key, .relay_drive, .armed);
`default_nettype wire

// ==== ssp_partner.sv ====
// Purpose: Trigger sources at the far side
// Assumes: One event per pulse
// Notes:   Lines idle low between pulses
`timescale 1ns/1ps
`default_nettype none
module ssp_partner (
  input  wire logic sys_clk,
  output logic      ext_trig,
  output logic      chained_trigger_line
);
  initial ext_trig = 1'b0;
  initial chained_trigger_line = 1'b0;
  // One pulse per advance, held three edges; only the raised line is released,
  // so a back-to-back pulse on the other line never sees a double assignment
  task automatic fire(input logic chain);
    if (chain) chained_trigger_line <= 1'b1;
    else ext_trig <= 1'b1;
    repeat (3) @(posedge sys_clk);
    if (chain) chained_trigger_line <= 1'b0;
    else ext_trig <= 1'b0;
  endtask : fire
endmodule : ssp_partner
`default_nettype wire

// ==== test_scan_sequencer_pattern_store.sv ====
// Purpose: Self-checking bench for ssp_top
// Assumes: Zero-wait bus
// Notes:   Expected relays from a small list model
`timescale 1ns/1ps
`default_nettype none
module test_scan_sequencer_pattern_store
  import ssp_pkg::*;
;
  logic        sys_clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, step_key = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, rdv, hrdata, relay_drive, pat;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'b010;
  logic        hreadyout, hresp, armed, ext_trig, chained_trigger_line;
  int          fails = 0, checks_done = 0, cyc = 0, f, c, p1, p2, loc;
  int          lst[$];                     // Scan list model
  always #5 sys_clk = ~sys_clk;
  ssp_top DUT (.sys_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready(hreadyout),
    .hwdata, .hrdata, .hreadyout, .hresp, .ext_trig, .chained_trigger_line, .step_key,
    .relay_drive, .armed);
  ssp_partner u_far (.sys_clk, .ext_trig, .chained_trigger_line);
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // One single AHB transfer; read data lands in rdv
  task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= 3'b010;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hsize <= 3'b000;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask : xf
  task automatic cmd(input int b);
    xf(1'b1, A_CMD, 32'h1 << b);
  endtask : cmd
  task automatic press;
    step_key <= 1'b1;
    repeat (3) @(posedge sys_clk);
    step_key <= 1'b0;
  endtask : press
  function automatic logic [31:0] pe(input logic [31:0] x);
    pe = {x[15:0] | x[31:16], x[15:0] | x[31:16]};
  endfunction : pe
  // Let events settle, then compare layer and relays
  task automatic look(input logic [1:0] st, input logic [31:0] rel);
    repeat (6) @(posedge sys_clk);
    xf(1'b0, A_STAT, 32'h0);
    chk("state", {30'h0, rdv[1:0]}, {30'h0, st});
    xf(1'b0, A_RELAY, 32'h0);
    chk("relay", rdv, rel);
  endtask : look
  task automatic end_of_test;
    if (fails == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      end_of_test();
    end
  end
  initial begin
    void'($urandom(11988));
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    xf(1'b0, A_LOC, 32'h0);
    chk("location", rdv, 32'h1);
    xf(1'b0, 8'(8'h34 + 4 * $urandom_range(50)), 32'h0); // Unmapped read, zero expected
    for (int i = 1; i <= 500; i++) begin // Fill every location with an empty pattern
      xf(1'b1, A_LOC, 32'(i));
      cmd(C_STORE);
    end
    f = 16 + $urandom_range(15);
    c = $urandom_range(15);
    p1 = $urandom_range(15);
    loc = 1 + $urandom_range(499);
    p2 = (p1 + 1 + $urandom_range(14)) % 16;
    pat = (32'h1 << p1) | (32'h1 << p2);
    xf(1'b1, A_FORB, 32'h1 << f);
    xf(1'b1, A_LADD, 32'(f));
    xf(1'b0, A_STAT, 32'h0);
    chk("refused", {25'h0, rdv[8:2]}, 32'h40);
    cmd(C_ACK);
    lst = '{c, (c + 1 + $urandom_range(14)) % 16};
    foreach (lst[i]) xf(1'b1, A_LADD, 32'(lst[i]));
    xf(1'b1, A_CFG, 32'h4 | (32'h2 << F_SCAN) | (32'h5 << F_CHAN));
    xf(1'b1, A_CNT, 32'h0002_0001);
    cmd(C_STEP);
    look(2'd1, 32'h0);
    u_far.fire(1'b0);
    look(2'd1, 32'h0);
    press();
    look(2'd2, 32'h0);
    u_far.fire(1'b0);
    look(2'd3, 32'h0);
    u_far.fire(1'b1);
    look(2'd3, 32'h1 << lst[0]);
    cmd(C_STEP);
    look(2'd2, 32'h1 << lst[1]);
    u_far.fire(1'b0);
    u_far.fire(1'b1);
    look(2'd3, 32'h1 << lst[0]);
    u_far.fire(1'b1);
    look(2'd0, 32'h1 << lst[1]);
    xf(1'b1, A_CLIST, pat);
    xf(1'b1, A_CFG, 32'h1 << F_SRCLST);
    xf(1'b1, A_LOC, 32'(loc));
    cmd(C_STORE);
    cmd(C_RECALL);
    look(2'd0, pat);
    xf(1'b1, A_CFG, (32'h1 << F_SINGLE) | (32'h1 << F_SRCLST));
    cmd(C_RECALL);
    look(2'd0, 32'h1 << ((p1 < p2) ? p1 : p2));
    cmd(C_OPEN);
    look(2'd0, 32'h0);
    cmd(C_LCLR);
    lst = '{512 + loc, c};
    foreach (lst[i]) xf(1'b1, A_LADD, 32'(lst[i]));
    xf(1'b1, A_CFG, (32'h1 << F_PAIR) | (32'h3 << F_CHAN));
    cmd(C_STEP);
    look(2'd3, 32'h0);
    cmd(C_BUSTRG);
    look(2'd3, pe(pat));
    cmd(C_BUSTRG);
    look(2'd3, pe(pat | (32'h1 << c)));
    cmd(C_BUSTRG);
    look(2'd3, pe(pat));
    cmd(C_OPEN);
    look(2'd0, 32'h0);
    xf(1'b1, A_RESTR, 32'h1 << (p1 + 16));
    repeat (520) @(posedge sys_clk);
    xf(1'b0, A_STAT, 32'h0);
    chk("list length", {24'h0, rdv[8:2]}, 32'h0);
    cmd(C_RECALL);
    look(2'd0, 32'h0);
    end_of_test();
  end
endmodule : test_scan_sequencer_pattern_store
`default_nettype wire
